// File: verilog/smc_pkg.sv
// Purpose: shared constants and carriers for the serial master clock and select timing block
// Assumes: one clock, ref_clk at 100 MHz
// Notes:   bit positions of the control words are kept here once
package smc_pkg;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned MASTER_BIT    = 0;
  localparam int unsigned PRESCALE_LSB  = 8;
  localparam int unsigned PRESCALE_MSB  = 15;
  localparam int unsigned PHASE_BIT     = 16;
  localparam int unsigned POLARITY_BIT  = 17;

  // ---------------------------------------------------------------------------
  // widths, reset values and timing counts
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned DELAY_W       = 8;
  localparam logic [7:0]  PRESCALE_ZERO_PERIOD = 8'h02;
  localparam logic [7:0]  SELECT_EXTRA_CYCLES  = 8'h02;
  localparam logic [7:0]  HOLD_EXTRA_CYCLES    = 8'h01;
  localparam logic        PIN_IDLE      = 1'b0;
  localparam logic        SELECT_IDLE   = 1'b1;

  // format word fields gathered into one carrier
  typedef struct packed {
    logic       polarity;
    logic       phase;
    logic [7:0] prescale;
  } smc_format_t;

  // chip select delay pair
  typedef struct packed {
    logic [DELAY_W-1:0] select_to_clock;
    logic [DELAY_W-1:0] clock_to_select;
  } smc_delay_t;

endpackage : smc_pkg

// File: verilog/smc_half_timer.sv
// Purpose: half-period tick generator of the serial clock
// Assumes: prescale is stable while run is high
// Notes:   odd periods give the first-to-second tick span one cycle longer than the second-to-first span
`timescale 1ns/10ps
module smc_half_timer
  import smc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] prescale,
  output logic            tick_first,
  output logic            tick_second
);

  logic [8:0] period;
  logic [8:0] half;
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;

  // ---------------------------------------------------------------------------
  // period length
  // ---------------------------------------------------------------------------
  // zero prescale behaves as period two, otherwise prescale plus one
  always_comb begin
    if (prescale == 8'h00) begin
      period = {1'b0, PRESCALE_ZERO_PERIOD};
    end else begin
      period = {1'b0, prescale} + 9'h001;
    end
    half = period >> 1;
  end

  // counter next value
  always_comb begin
    cnt_next = cnt_reg;
    if (!run || cnt_reg == period - 9'h001) begin
      cnt_next = 9'h000;
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= 9'h000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_first  = run && (cnt_reg == half - 9'h001);
  assign tick_second = run && (cnt_reg == period - 9'h001);

endmodule : smc_half_timer

// File: verilog/smc_master.sv
// Purpose: serial master clock generation, chip select timing and shifting
// Assumes: control words stable while busy; master_in_pin is asynchronous
// Notes:   one word per start pulse, msb first
// Summary of operation
// - serial clock period is prescale plus one cycles, zero prescale gives two.
// - master enable bit set makes the block drive clock and master out.
// - phase bit picks one of two distinct data phase timings.
// - polarity bit picks idle level and thus the active reference edge.
// - both select delays come from the software delay configuration word.
// - phase one without hold: select leads first edge by half period plus delay plus two.
// - phase one: master out valid half a period before first active edge.
`timescale 1ns/10ps
module smc_master
  import smc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [31:0]       global_control_reg_one,
  input  wire logic [31:0]       data_format_reg,
  input  wire logic [15:0]       delay_config_reg,
  input  wire logic              keep_select_asserted,
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              master_in_pin,
  output logic                   serial_clock_pin,
  output logic                   serial_clock_oe_n,
  output logic                   master_out_pin,
  output logic                   master_out_oe_n,
  output logic                   select_n,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rx_data
);

  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HALF, ST_SHIFT, ST_TAIL} smc_state_t;

  smc_format_t fmt;
  smc_delay_t  dly;
  logic        master_en;
  assign fmt       = '{polarity: data_format_reg[POLARITY_BIT], phase: data_format_reg[PHASE_BIT],
                       prescale: data_format_reg[PRESCALE_MSB:PRESCALE_LSB]};
  assign dly       = delay_config_reg;
  assign master_en = global_control_reg_one[MASTER_BIT];

  // ---------------------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------------------
  logic miso_s1_reg;
  logic miso_s2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      miso_s1_reg <= PIN_IDLE;
      miso_s2_reg <= PIN_IDLE;
    end else begin
      miso_s1_reg <= master_in_pin;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  smc_state_t        state_reg, state_next;
  logic [8:0]        wait_reg, wait_next;
  logic [3:0]        bit_reg, bit_next;
  logic [DATA_W-1:0] tx_reg, tx_next;
  logic [DATA_W-1:0] rx_reg, rx_next;
  logic              sclk_reg, sclk_next;
  logic              mosi_reg, mosi_next;
  logic              cs_reg, cs_next;
  logic              done_reg, done_next;
  logic              oe_reg, oe_next;
  logic              tick_first;
  logic              tick_second;
  logic              run;

  assign run = (state_reg == ST_HALF) || (state_reg == ST_SHIFT);

  smc_half_timer u_timer (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .run         (run),
    .prescale    (fmt.prescale),
    .tick_first  (tick_first),
    .tick_second (tick_second)
  );

  // next-state logic; with hold set one more cycle of lead is added
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    bit_next   = bit_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    sclk_next  = sclk_reg;
    mosi_next  = mosi_reg;
    cs_next    = cs_reg;
    done_next  = 1'b0;
    oe_next    = !master_en;
    case (state_reg)
      ST_IDLE: begin
        sclk_next = fmt.polarity;
        cs_next   = SELECT_IDLE;
        if (start && master_en) begin
          cs_next   = !SELECT_IDLE;
          tx_next   = tx_data << 1;
          mosi_next = tx_data[DATA_W-1];
          bit_next  = 4'h0;
          wait_next = {1'b0, dly.select_to_clock} + {1'b0, SELECT_EXTRA_CYCLES}
                      + {8'h00, keep_select_asserted} - 9'h001;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (wait_reg == 9'h000) begin
          if (fmt.phase) begin
            state_next = ST_HALF;
          end else begin
            // phase zero: the first edge ends the lead, msb has stood since select
            sclk_next  = !sclk_reg;
            state_next = ST_SHIFT;
          end
        end else begin
          wait_next = wait_reg - 9'h001;
        end
      end
      ST_HALF: begin
        // phase one idles a half period with data already out, then samples on the first edge
        if (tick_first) begin
          sclk_next  = !sclk_reg;
          rx_next    = {rx_reg[DATA_W-2:0], miso_s2_reg};
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // first tick samples in both phases, second tick moves data, so they never share an edge
        if (tick_first) begin
          sclk_next = !sclk_reg;
          rx_next   = {rx_reg[DATA_W-2:0], miso_s2_reg};
          if (!fmt.phase) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'(DATA_W - 1)) begin
              wait_next  = {1'b0, dly.clock_to_select} + {1'b0, HOLD_EXTRA_CYCLES};
              state_next = ST_TAIL;
            end
          end
        end
        if (tick_second) begin
          sclk_next = !sclk_reg;
          mosi_next = tx_reg[DATA_W-1];
          tx_next   = tx_reg << 1;
          if (fmt.phase) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'(DATA_W - 1)) begin
              wait_next  = {1'b0, dly.clock_to_select} + {1'b0, HOLD_EXTRA_CYCLES};
              state_next = ST_TAIL;
            end
          end
        end
      end
      ST_TAIL: begin
        if (wait_reg == 9'h000) begin
          cs_next    = SELECT_IDLE;
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end else begin
          wait_next = wait_reg - 9'h001;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wait_reg  <= 9'h000;
      bit_reg   <= 4'h0;
      tx_reg    <= '0;
      rx_reg    <= '0;
      sclk_reg  <= PIN_IDLE;
      mosi_reg  <= PIN_IDLE;
      cs_reg    <= SELECT_IDLE;
      done_reg  <= 1'b0;
      oe_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      bit_reg   <= bit_next;
      tx_reg    <= tx_next;
      rx_reg    <= rx_next;
      sclk_reg  <= sclk_next;
      mosi_reg  <= mosi_next;
      cs_reg    <= cs_next;
      done_reg  <= done_next;
      oe_reg    <= oe_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic busy_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != ST_IDLE);
    end
  end
  assign serial_clock_pin  = sclk_reg;
  assign serial_clock_oe_n = oe_reg;
  assign master_out_pin    = mosi_reg;
  assign master_out_oe_n   = oe_reg;
  assign select_n          = cs_reg;
  assign busy              = busy_reg;
  assign done              = done_reg;
  assign rx_data           = rx_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence seq_start;
    state_reg == ST_IDLE && start && master_en;
  endsequence

  AST_SELECT_ON_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_start |=> !select_n) else $error("select not asserted after start");
  AST_CLOCK_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> serial_clock_pin == $past(fmt.polarity))
    else $error("clock idle level wrong");
  AST_DRIVE_EN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    master_en |=> !serial_clock_oe_n) else $error("pins not driven in master mode");
  AST_TICK_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run && fmt.prescale == 8'h00 && tick_second |-> !tick_first) else $error("tick overlap");
  AST_PHASE_HALF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_LEAD && wait_reg == 9'h000 && fmt.phase |=> state_reg == ST_HALF)
    else $error("phase one skipped half period");
  AST_DATA_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_HALF |=> $stable(master_out_pin)) else $error("data moved before first edge");
  AST_SAMPLE_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_SHIFT && tick_second |=> $stable(rx_data))
    else $error("sampled on change edge");
  AST_TAIL_DELAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == ST_SHIFT && state_next == ST_TAIL |=> wait_reg == {1'b0, dly.clock_to_select} + 9'h001)
    else $error("tail delay wrong");

endmodule : smc_master

// File: testbench/smc_slave_model.sv
// Purpose: behavioural serial slave facing the master block
// Assumes: mode bits match the master's format word
// Notes:   a released data line shows the inverse of its last bit, no pull resistor
`timescale 1ns/10ps
module smc_slave_model
  import smc_pkg::*;
(
  input  wire logic              serial_clock_pin,
  input  wire logic              select_n,
  input  wire logic              master_out_pin,
  input  wire logic              polarity,
  input  wire logic              phase,
  input  wire logic [DATA_W-1:0] reply,
  output logic                   master_in_pin,
  output logic [DATA_W-1:0]      got
);
  logic [DATA_W-1:0] shift_q;
  initial master_in_pin = 1'b0;
  initial got = '0;
  // -------------------------------------------------------------------------
  // select edges: phase 1 shows the msb before any clock edge
  // -------------------------------------------------------------------------
  always @(select_n) begin
    if (select_n === 1'b0) begin
      shift_q = reply;
      got = '0;
      if (phase) begin
        master_in_pin = shift_q[DATA_W-1];
        shift_q = shift_q << 1;
      end
    end else begin
      master_in_pin = ~master_in_pin; // released: never leave a stale bit
    end
  end
  // leading edge leaves the idle level; phase 1 samples on it, phase 0 on the trailing edge
  always @(serial_clock_pin) begin
    if (select_n === 1'b0) begin
      if (!((serial_clock_pin != polarity) ^ phase)) begin
        got = {got[DATA_W-2:0], master_out_pin};
      end else begin
        master_in_pin = shift_q[DATA_W-1];
        shift_q = shift_q << 1;
      end
    end
  end
endmodule : smc_slave_model

// File: testbench/tb.sv
// Purpose: self-checking bench of the serial master timing block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   receive data only checked at periods long enough for the input sync
`timescale 1ns/10ps
module tb;
  import smc_pkg::*;
  logic ref_clk, rst_n, keep_select_asserted, start, master_in_pin;
  logic [31:0] global_control_reg_one, data_format_reg;
  logic [15:0] delay_config_reg;
  logic [7:0]  tx_data, rx_data, reply, got;
  logic serial_clock_pin, serial_clock_oe_n, master_out_pin, master_out_oe_n, select_n, busy, done;
  int   num_errors = 0, comparisons = 0, cycles = 0, lead, per;

  smc_master u_smc_master (.ref_clk(ref_clk), .rst_n(rst_n), .global_control_reg_one(global_control_reg_one),
    .data_format_reg(data_format_reg), .delay_config_reg(delay_config_reg),
    .keep_select_asserted(keep_select_asserted), .start(start), .tx_data(tx_data), .master_in_pin(master_in_pin),
    .serial_clock_pin(serial_clock_pin), .serial_clock_oe_n(serial_clock_oe_n), .master_out_pin(master_out_pin),
    .master_out_oe_n(master_out_oe_n), .select_n(select_n), .busy(busy), .done(done), .rx_data(rx_data));
  smc_slave_model u_smc_slave_model (.serial_clock_pin(serial_clock_pin), .select_n(select_n),
    .master_out_pin(master_out_pin), .polarity(data_format_reg[17]), .phase(data_format_reg[16]),
    .reply(reply), .master_in_pin(master_in_pin), .got(got));

  // -------------------------------------------------------------------------
  // clock, timeout and shared tasks
  // -------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hung handshake ends here rather than running forever
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // one word; measures select lead and clock period in ref_clk cycles
  task automatic xfer(logic [7:0] ps, logic ph, logic pol, logic hold, logic [7:0] c2t, logic [7:0] tx, logic rx_ok);
    int n, c_sel, c_e1, c_e2;
    logic last_clk, msb_ok;
    data_format_reg = {14'h0, pol, ph, ps, 8'h00};
    delay_config_reg = {c2t, 8'h03};
    keep_select_asserted = hold;
    reply = ~tx ^ 8'h5a;
    tick();
    tick();
    chk("idle clock", {31'h0, pol}, {31'h0, serial_clock_pin});
    tx_data = tx;
    start = 1'b1;
    tick();
    start = 1'b0;
    chk("busy", 32'h1, {31'h0, busy});
    c_sel = -1; c_e1 = -1; c_e2 = -1; msb_ok = 1'b1; last_clk = pol;
    for (n = 1; n < 5000 && done !== 1'b1; n++) begin
      if (c_sel < 0 && select_n === 1'b0) c_sel = n;
      if (serial_clock_pin !== last_clk && serial_clock_pin !== pol) begin
        if (c_e1 < 0) c_e1 = n;
        else if (c_e2 < 0) c_e2 = n;
      end
      if (c_sel >= 0 && c_e1 < 0 && master_out_pin !== tx[7]) msb_ok = 1'b0;
      last_clk = serial_clock_pin;
      tick();
    end
    lead = c_e1 - c_sel;
    per = c_e2 - c_e1;
    chk("done", 32'h1, {31'h0, done});
    chk("select released", 32'h1, {31'h0, select_n});
    chk("busy released", 32'h0, {31'h0, busy});
    chk("msb ahead of edge", 32'h1, {31'h0, msb_ok});
    chk("slave got", {24'h0, tx}, {24'h0, got});
    if (rx_ok) chk("rx data", {24'h0, reply}, {24'h0, rx_data});
  endtask : xfer

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic test_disabled();
    global_control_reg_one = 32'h0;
    tick();
    tick();
    chk("clock oe_n off", 32'h1, {31'h0, serial_clock_oe_n});
    chk("data oe_n off", 32'h1, {31'h0, master_out_oe_n});
    start = 1'b1;
    tick();
    start = 1'b0;
    repeat (20) begin
      tick();
      chk("select when disabled", 32'h1, {31'h0, select_n});
    end
    global_control_reg_one = 32'h1;
    tick();
    tick();
    chk("clock oe_n on", 32'h0, {31'h0, serial_clock_oe_n});
    chk("data oe_n on", 32'h0, {31'h0, master_out_oe_n});
    $display("test disabled done");
  endtask : test_disabled
  task automatic test_period();
    logic [7:0] ps_list [4] = '{8'h00, 8'h01, 8'h04, 8'hff};
    foreach (ps_list[i]) begin
      xfer(ps_list[i], 1'b0, 1'b0, 1'b0, 8'h01, 8'ha5, ps_list[i] == 8'hff);
      chk("period", (ps_list[i] == 8'h00) ? 32'h2 : 32'(ps_list[i]) + 1, per);
    end
    $display("test period done");
  endtask : test_period
  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      xfer(8'h09, m[0], m[1], 1'b0, 8'h02, 8'h3c ^ 8'(m * 17), 1'b1);
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_lead();
    xfer(8'h09, 1'b0, 1'b0, 1'b0, 8'h03, 8'h81, 1'b1);
    chk("phase 0 lead", 32'd5, lead);
    xfer(8'h09, 1'b1, 1'b0, 1'b0, 8'h03, 8'h7e, 1'b1);
    chk("phase 1 lead", 32'd10, lead);
    xfer(8'h09, 1'b1, 1'b1, 1'b1, 8'h05, 8'hc3, 1'b1);
    chk("phase 1 hold lead", 32'd13, lead);
    $display("test lead done");
  endtask : test_lead

  initial begin
    rst_n = 1'b0; start = 1'b0; keep_select_asserted = 1'b0; tx_data = 8'h00; reply = 8'h00;
    global_control_reg_one = 32'h1; data_format_reg = 32'h0; delay_config_reg = 16'h0;
    tick();
    tick();
    rst_n = 1'b1;
    test_disabled();
    test_period();
    test_modes();
    test_lead();
    test_done();
  end
endmodule : tb
